/* rtl/adc_conversion_pkg.sv */
// Constants shared by the converter control logic.
// Overview of operation
// - Channel select 1 picks the first analog input, 0 picks the second.
// - Ten-bit result: high register holds bits 9..2, low register bits 1..0.
// - Converter clock is peripheral clock divided by the 5-bit divider field.
// - A divider field of zero divides by thirty-two.
// - With core freeze set, a launched conversion stalls the CPU core until done.
// - Hardware clears the core freeze bit when the conversion completes.
// - Interrupts raised during the freeze stay pending until the conversion ends.
// - Enable bit activates the converter; clearing it puts it in standby.
// - Writing start launches a conversion; start reads one until hardware clears it.
// - Result lands in both result registers eleven converter clocks after start.
// - Done flag sets when the result is ready and only software clears it.
// - With the converter interrupt enable set, a set done flag requests an interrupt.
// - Reserved bits read zero; software never writes ones to them.
// - Control bits: freeze 6, enable 5, done 4, start 3, channel select 0.
// - All four registers reset to zero; both result registers are read-only.
package adc_conversion_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [7:0] ADDR_CLOCK_DIVIDER = 8'hF2;
	localparam logic [7:0] ADDR_CONTROL = 8'hF3;
	localparam logic [7:0] ADDR_RESULT_LOW = 8'hF4;
	localparam logic [7:0] ADDR_RESULT_HIGH = 8'hF5;

	// ==========================================================
	// Field positions and widths
	localparam int CTRL_FREEZE_BIT = 6;
	localparam int CTRL_ENABLE_BIT = 5;
	localparam int CTRL_DONE_BIT = 4;
	localparam int CTRL_START_BIT = 3;
	localparam int CTRL_CHANNEL_BIT = 0;
	localparam int DIVIDE_WIDTH = 5;
	localparam int RESULT_WIDTH = 10;
	localparam int RESULT_LOW_WIDTH = 2;

	// ==========================================================
	// Reset values and timing
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [DIVIDE_WIDTH-1:0] DIVIDE_ZERO = 5'h00;
	localparam logic [5:0] DIVIDE_ZERO_FACTOR = 6'h20;
	localparam logic [3:0] CONVERSION_PERIODS = 4'hB;

	typedef enum logic [1:0] {
		CONV_IDLE,
		CONV_SAMPLE,
		CONV_RESOLVE
	} conv_state_type;

endpackage

/* rtl/converter_clock_divider.sv */
// Converter clock enable generator dividing the peripheral clock.
`timescale 1ns/100ps
module converter_clock_divider (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [adc_conversion_pkg::DIVIDE_WIDTH-1:0] clock_divide_field,
	output logic tick
);

	logic [5:0] count_q;
	logic [5:0] count_d;
	logic [5:0] factor;

	always_comb begin
		if (clock_divide_field == adc_conversion_pkg::DIVIDE_ZERO) begin
			factor = adc_conversion_pkg::DIVIDE_ZERO_FACTOR;
		end else begin
			factor = {1'b0, clock_divide_field};
		end
		tick = run && (count_q >= factor - 6'h01);
		if (!run || tick) begin
			count_d = 6'h00;
		end else begin
			count_d = count_q + 6'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= 6'h00;
		end else begin
			count_q <= count_d;
		end
	end

endmodule

/* rtl/adc_conversion_control.sv */
// Control, registers and successive approximation sequencing of the two-channel converter.
`timescale 1ns/100ps
module adc_conversion_control (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic converter_irq_enable,
	output logic converter_irq,
	output logic cpu_freeze,
	output logic irq_hold,
	output logic converter_standby,
	output logic analog_input_first_sel,
	output logic sample_hold,
	output logic [adc_conversion_pkg::RESULT_WIDTH-1:0] dac_code,
	input wire logic comparator_out
);

	localparam int RW = adc_conversion_pkg::RESULT_WIDTH;
	localparam int DW = adc_conversion_pkg::DIVIDE_WIDTH;

	// ==========================================================
	// Comparator synchroniser
	logic comp_meta_q;
	logic comp_sync_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			comp_meta_q <= 1'b0;
			comp_sync_q <= 1'b0;
		end else begin
			comp_meta_q <= comparator_out;
			comp_sync_q <= comp_meta_q;
		end
	end

	// ==========================================================
	// Register and sequencer state
	adc_conversion_pkg::conv_state_type state_q, state_d;
	logic [DW-1:0] divide_q, divide_d;
	logic freeze_q, freeze_d;
	logic enable_q, enable_d;
	logic done_q, done_d;
	logic channel_q, channel_d;
	logic [3:0] period_q, period_d;
	logic [RW-1:0] trial_q, trial_d;
	logic [RW-1:0] bit_q, bit_d;
	logic [RW-1:0] result_q, result_d;
	logic [7:0] rdata_q, rdata_d;
	logic tick;
	logic write_ctrl;
	logic launch;
	logic finish;
	logic busy;

	converter_clock_divider u_divider (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.run(enable_q),
		.clock_divide_field(divide_q),
		.tick(tick)
	);

	assign busy = (state_q != adc_conversion_pkg::CONV_IDLE);
	assign write_ctrl = sfr_wr && (sfr_addr == adc_conversion_pkg::ADDR_CONTROL);
	// no launch while busy or disabled
	assign launch = write_ctrl && sfr_wdata[adc_conversion_pkg::CTRL_START_BIT] && !busy
		&& enable_q && sfr_wdata[adc_conversion_pkg::CTRL_ENABLE_BIT];
	assign finish = (state_q == adc_conversion_pkg::CONV_RESOLVE) && tick
		&& (period_q == adc_conversion_pkg::CONVERSION_PERIODS - 4'h1);

	always_comb begin
		state_d = state_q;
		divide_d = divide_q;
		freeze_d = freeze_q;
		enable_d = enable_q;
		done_d = done_q;
		channel_d = channel_q;
		period_d = period_q;
		trial_d = trial_q;
		bit_d = bit_q;
		result_d = result_q;
		if (sfr_wr && sfr_addr == adc_conversion_pkg::ADDR_CLOCK_DIVIDER) begin
			divide_d = sfr_wdata[DW-1:0];
		end
		if (write_ctrl) begin
			freeze_d = sfr_wdata[adc_conversion_pkg::CTRL_FREEZE_BIT];
			enable_d = sfr_wdata[adc_conversion_pkg::CTRL_ENABLE_BIT];
			channel_d = sfr_wdata[adc_conversion_pkg::CTRL_CHANNEL_BIT];
			if (!sfr_wdata[adc_conversion_pkg::CTRL_DONE_BIT]) begin
				done_d = 1'b0;
			end
		end
		unique case (state_q)
			adc_conversion_pkg::CONV_IDLE: begin
				if (launch) begin
					state_d = adc_conversion_pkg::CONV_SAMPLE;
					period_d = 4'h0;
					trial_d = {1'b1, {(RW-1){1'b0}}};
					bit_d = {1'b1, {(RW-1){1'b0}}};
				end
			end
			adc_conversion_pkg::CONV_SAMPLE: begin
				if (tick) begin
					state_d = adc_conversion_pkg::CONV_RESOLVE;
					period_d = period_q + 4'h1;
				end
			end
			adc_conversion_pkg::CONV_RESOLVE: begin
				if (tick) begin
					period_d = period_q + 4'h1;
					bit_d = bit_q >> 1;
					trial_d = (comp_sync_q ? trial_q : (trial_q & ~bit_q)) | (bit_q >> 1);
					if (finish) begin
						state_d = adc_conversion_pkg::CONV_IDLE;
						result_d = comp_sync_q ? trial_q : (trial_q & ~bit_q);
						done_d = 1'b1;
						freeze_d = 1'b0;
					end
				end
			end
		endcase
		if (!enable_d) begin
			state_d = adc_conversion_pkg::CONV_IDLE;
		end
	end

	always_comb begin
		rdata_d = rdata_q;
		if (sfr_rd) begin
			rdata_d = adc_conversion_pkg::REG_RESET;
			unique case (sfr_addr)
				adc_conversion_pkg::ADDR_CLOCK_DIVIDER: begin
					rdata_d[DW-1:0] = divide_q;
				end
				adc_conversion_pkg::ADDR_CONTROL: begin
					rdata_d[adc_conversion_pkg::CTRL_FREEZE_BIT] = freeze_q;
					rdata_d[adc_conversion_pkg::CTRL_ENABLE_BIT] = enable_q;
					rdata_d[adc_conversion_pkg::CTRL_DONE_BIT] = done_q;
					rdata_d[adc_conversion_pkg::CTRL_START_BIT] = busy;
					rdata_d[adc_conversion_pkg::CTRL_CHANNEL_BIT] = channel_q;
				end
				adc_conversion_pkg::ADDR_RESULT_LOW: begin
					rdata_d[adc_conversion_pkg::RESULT_LOW_WIDTH-1:0] =
						result_q[adc_conversion_pkg::RESULT_LOW_WIDTH-1:0];
				end
				adc_conversion_pkg::ADDR_RESULT_HIGH: begin
					rdata_d = result_q[RW-1:adc_conversion_pkg::RESULT_LOW_WIDTH];
				end
				default: begin
					rdata_d = adc_conversion_pkg::REG_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= adc_conversion_pkg::CONV_IDLE;
			divide_q <= adc_conversion_pkg::DIVIDE_ZERO;
			freeze_q <= 1'b0;
			enable_q <= 1'b0;
			done_q <= 1'b0;
			channel_q <= 1'b0;
			period_q <= 4'h0;
			trial_q <= {RW{1'b0}};
			bit_q <= {RW{1'b0}};
			result_q <= {RW{1'b0}};
			rdata_q <= adc_conversion_pkg::REG_RESET;
		end else begin
			state_q <= state_d;
			divide_q <= divide_d;
			freeze_q <= freeze_d;
			enable_q <= enable_d;
			done_q <= done_d;
			channel_q <= channel_d;
			period_q <= period_d;
			trial_q <= trial_d;
			bit_q <= bit_d;
			result_q <= result_d;
			rdata_q <= rdata_d;
		end
	end

	// ==========================================================
	// Outputs
	assign sfr_rdata = rdata_q;
	assign converter_irq = done_q && converter_irq_enable;
	assign cpu_freeze = freeze_q && busy;
	assign irq_hold = freeze_q && busy;
	assign converter_standby = !enable_q;
	assign analog_input_first_sel = channel_q;
	assign sample_hold = (state_q == adc_conversion_pkg::CONV_SAMPLE);
	assign dac_code = trial_q;

endmodule

/* verification/adc_conversion_control_properties.sv */
// Port-level assertions for the converter control block.
`timescale 1ns/100ps
module adc_conversion_checker (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic converter_irq_enable,
	input wire logic converter_irq,
	input wire logic cpu_freeze,
	input wire logic irq_hold,
	input wire logic converter_standby,
	input wire logic analog_input_first_sel,
	input wire logic sample_hold
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence ctrl_write;
		sfr_wr && sfr_addr == adc_conversion_pkg::ADDR_CONTROL;
	endsequence
	a_hold_tracks_freeze: assert property (irq_hold == cpu_freeze)
		else $error("hold and freeze differ");
	a_standby_from_enable: assert property (ctrl_write |=> converter_standby == !$past(sfr_wdata[5]))
		else $error("standby does not follow enable");
	a_channel_from_write: assert property (ctrl_write |=> analog_input_first_sel == $past(sfr_wdata[0]))
		else $error("channel select not taken");
	a_irq_needs_enable: assert property (converter_irq |-> converter_irq_enable)
		else $error("interrupt without enable");
	a_sample_when_active: assert property (sample_hold |-> !converter_standby)
		else $error("sampling in standby");
	a_freeze_needs_start: assert property ($rose(cpu_freeze) |-> $past(sfr_wr && sfr_wdata[6] && sfr_wdata[3]))
		else $error("freeze without start write");
	a_freeze_bounded: assert property ($rose(cpu_freeze) |-> ##[1:360] !cpu_freeze)
		else $error("freeze too long");
	a_freeze_ends_done: assert property ($fell(cpu_freeze) && !converter_standby && converter_irq_enable |-> converter_irq)
		else $error("freeze ended without done");
	a_reserved_reads_zero: assert property (sfr_rd && sfr_addr == adc_conversion_pkg::ADDR_RESULT_LOW |=> sfr_rdata[7:2] == 6'h00)
		else $error("reserved low bits set");
endmodule

/* verification/analog_front_model.sv */
// Behavioural analog inputs, sample-and-hold and comparator.
`timescale 1ns/100ps
module analog_front_model (
	input wire logic clk_sys,
	input wire logic analog_input_first_sel,
	input wire logic sample_hold,
	input wire logic [9:0] dac_code,
	input wire logic [9:0] level_first,
	input wire logic [9:0] level_second,
	output logic comparator_out
);
	logic [9:0] held = 10'h000;
	always @(posedge clk_sys) begin
		if (sample_hold) begin
			held <= analog_input_first_sel ? level_first : level_second;
		end
	end
	assign comparator_out = (held >= dac_code);
endmodule

/* verification/test_adc_conversion_control.sv */
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
module test_adc_conversion_control;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, a, ctl;
	logic sfr_wr = 1'b0, sfr_rd = 1'b0, irq_en = 1'b1, rd_pend = 1'b0, comp, irq, frz, hold, stby, fsel, sh;
	logic [9:0] dac, lvl_a = 10'h000, lvl_b = 10'h000, v;
	logic [7:0] exp_q[$];
	logic [4:0] divs [4] = '{5'h00, 5'h04, 5'h09, 5'h05};
	int err_count = 0, checks_done = 0, cycles = 0, seed = 92, t, n;
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	adc_conversion_control uut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .converter_irq_enable(irq_en),
		.converter_irq(irq), .cpu_freeze(frz), .irq_hold(hold), .converter_standby(stby),
		.analog_input_first_sel(fsel), .sample_hold(sh), .dac_code(dac), .comparator_out(comp));
	analog_front_model far_side (.clk_sys(clk_sys), .analog_input_first_sel(fsel), .sample_hold(sh),
		.dac_code(dac), .level_first(lvl_a), .level_second(lvl_b), .comparator_out(comp));
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk_sys);
		sfr_addr <= ad;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk_sys);
		sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] e);
		@(posedge clk_sys);
		sfr_addr <= ad;
		sfr_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk_sys);
		sfr_rd <= 1'b0;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ==========================================================
	// Read watcher and timeout
	always @(posedge clk_sys) begin
		if (rd_pend) begin
			chk("read data", exp_q.pop_front(), sfr_rdata);
		end
		rd_pend <= sfr_rd;
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			err_count++;
			report_and_stop();
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		chk("standby", 8'h01, {7'h00, stby});
		for (a = 8'hF2; a != 8'hF7; a++) begin
			rd(a, 8'h00);
		end
		wr(8'hF2, 8'hFF);
		rd(8'hF2, 8'h1F);
		for (a = 8'hF4; a != 8'hF6; a++) begin
			wr(a, 8'hFF);
			rd(a, 8'h00);
		end
		wr(8'hF3, 8'h08);
		rd(8'hF3, 8'h00);
		$display("register test done");
		for (int i = 0; i < 4; i++) begin
			ctl = {1'b0, i[1], 1'b1, 1'b0, 1'b1, 2'b00, i[0]};
			lvl_a <= 10'($random(seed));
			lvl_b <= 10'($random(seed));
			wr(8'hF2, {3'h0, divs[i]});
			wr(8'hF3, ctl & 8'h21);
			@(negedge clk_sys);
			chk("standby", 8'h00, {7'h00, stby});
			repeat (40) @(posedge clk_sys);
			wr(8'hF3, ctl);
			t = cycles;
			rd(8'hF3, ctl);
			chk("freeze", {7'h00, i[1]}, {7'h00, frz});
			wr(8'hF3, ctl);
			while (irq !== 1'b1 && cycles - t < 400) @(posedge clk_sys);
			n = (divs[i] == 5'h00) ? 32 : divs[i];
			chk("length ok", 8'h01, {7'h00, cycles - t >= 10 * n - 1 && cycles - t <= 11 * n + 3});
			v = i[0] ? lvl_a : lvl_b;
			rd(8'hF3, ctl & 8'h21 | 8'h10);
			rd(8'hF5, v[9:2]);
			rd(8'hF4, {6'h00, v[1:0]});
			chk("freeze", 8'h00, {7'h00, frz});
			irq_en <= 1'b0;
			@(posedge clk_sys);
			@(posedge clk_sys);
			chk("masked irq", 8'h00, {7'h00, irq});
			irq_en <= 1'b1;
			wr(8'hF3, ctl & 8'h21);
			@(posedge clk_sys);
			chk("cleared irq", 8'h00, {7'h00, irq});
			$display("conversion %0d done", i);
		end
		repeat (4) @(posedge clk_sys);
		report_and_stop();
	end
endmodule
bind adc_conversion_control adc_conversion_checker props (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
	.converter_irq_enable(converter_irq_enable), .converter_irq(converter_irq), .cpu_freeze(cpu_freeze),
	.irq_hold(irq_hold), .converter_standby(converter_standby),
	.analog_input_first_sel(analog_input_first_sel), .sample_hold(sample_hold));
